// ===== verif/rfpc_host_model.sv
// Host model for the serial link of the FIFO, power table and pin control block.
// Assumes clk_sys at 100 ns; link clock of 800 ns, standing low between frames.
`timescale 1ns/1ps
`default_nettype none
module rfpc_host_model (
  input wire logic clk_sys, // System clock
  output logic csLow, // Select, low active
  output logic sclk, // Link clock
  output logic si, // Data to device
  input wire logic so // Data from device
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    csLow = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Whole system cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Levels set while deselected, latched at the next select fall
  task automatic pins(input logic sc, input logic d);
    @(posedge clk_sys);
    sclk <= sc;
    si <= d;
    cyc(4);
  endtask
  // Open a frame; the first status bit needs a few cycles to settle
  task automatic select();
    @(posedge clk_sys);
    csLow <= 1'b0;
    cyc(6);
  endtask
  // Close a frame: ends a burst and clears the table index
  task automatic deselect();
    @(posedge clk_sys);
    csLow <= 1'b1;
    si <= ~si; // No stale bit left on the line
    cyc(8);
  endtask
  // One byte, MSB first, mode 0, four cycles per half period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_sys);
      sclk <= 1'b0;
      si <= tx[i];
      cyc(3);
      @(posedge clk_sys);
      sclk <= 1'b1;
      rx[i] = so;
      cyc(3);
    end
    @(posedge clk_sys);
    sclk <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_radio_fifo_table_pin_control.sv
// Self-checking bench for rfpc_spi_fifo, with a queue model of both FIFOs and the table.
// Assumes rfpc_host_model drives the link; radio side is driven here directly.
`timescale 1ns/1ps
`default_nettype none
module tb_radio_fifo_table_pin_control;
  import rfpc_pkg::*;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic clk_sys, rst, csLow, sclk, si, soPin, soOe, gdo0In, gdo0Out, gdo0Oe, serialTxData;
  logic radioAsleep, sleepEntry, pinCtrlEn, serialMode, gdo1Generic, gdo1Level, gdo0Level;
  logic flushTx, flushRx, txPop, rxPush, pdStb, txStb, idleStb, rxStb, wakeStb;
  logic [2:0] mainState, paSel;
  logic [7:0] paCtrl, txData, rxPushData, st, d;
  logic [6:0] txCount, rxCount;
  logic [7:0] txQ[$], rxQ[$]; // Expected FIFO contents
  logic [2:0] flSt[5] = '{ST_RX, ST_TX, ST_IDLE, ST_RXOVF, ST_TXUNF}; // Flush attempts
  int failures, samplesChecked, seed, cnt[5], snap[5], pa[8];
  // Released status pin shows the opposite of its driven level
  rfpc_host_model i_host (.clk_sys(clk_sys), .csLow(csLow), .sclk(sclk), .si(si),
    .so(soOe ? soPin : ~soPin));
  rfpc_spi_fifo i_dut (.clk_sys(clk_sys), .rst(rst), .chip_select_low(csLow), .sclkPin(sclk),
    .siPin(si), .shared_status_pin(soPin), .sharedStatusOe(soOe), .general_output_zero(gdo0In),
    .gdo0Out(gdo0Out), .gdo0Oe(gdo0Oe), .mainState(mainState), .radioAsleep(radioAsleep),
    .sleepEntry(sleepEntry), .pinCtrlEn(pinCtrlEn), .serialMode(serialMode),
    .gdo1Generic(gdo1Generic), .gdo1Level(gdo1Level), .gdo0Level(gdo0Level),
    .flush_tx_strobe(flushTx), .flush_rx_strobe(flushRx), .power_level_select(paSel),
    .paCtrl(paCtrl), .txPop(txPop), .txData(txData), .txCount(txCount), .rxPush(rxPush),
    .rxPushData(rxPushData), .rxCount(rxCount), .serialTxData(serialTxData),
    .power_down_strobe(pdStb), .transmit_strobe(txStb), .idle_strobe(idleStb),
    .receive_strobe(rxStb), .wakeStrobe(wakeStb));
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Count every strobe pulse; deltas are compared per command
  always @(posedge clk_sys) begin
    cnt[0] += (pdStb === 1'b1);
    cnt[1] += (txStb === 1'b1);
    cnt[2] += (idleStb === 1'b1);
    cnt[3] += (rxStb === 1'b1);
    cnt[4] += (wakeStb === 1'b1);
  end
  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp, input string what);
    chkByte({7'h00, got}, {7'h00, exp}, what);
  endtask
  task automatic test_done();
    $display("failures=%0d samplesChecked=%0d", failures, samplesChecked);
    if (failures == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Status byte: state code and free TX space, saturated at 15
  function automatic logic [7:0] stat(input int free);
    return {1'b0, mainState, (free > 15) ? STAT_CNT_MAX : 4'(free)};
  endfunction
  task automatic counts();
    chkByte({1'b0, txCount}, 8'(txQ.size()), "tx count");
    chkByte({1'b0, rxCount}, 8'(rxQ.size()), "rx count");
  endtask
  // TX write with header hdr and n random data bytes; full FIFO drops the byte
  task automatic txWrite(input logic [7:0] hdr, input int n);
    logic [7:0] exp;
    i_host.xfer(hdr, st);
    chkByte(st, stat(FIFO_DEPTH - txQ.size()), "header status");
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      exp = stat(FIFO_DEPTH - txQ.size());
      i_host.xfer(d, st);
      chkByte(st, exp, "tx status");
      if (txQ.size() < FIFO_DEPTH) txQ.push_back(d);
    end
  endtask
  // RX read with header hdr, n bytes; never reads past the model's content
  task automatic rxRead(input logic [7:0] hdr, input int n);
    i_host.xfer(hdr, st);
    chkByte(st, stat(FIFO_DEPTH - txQ.size()), "read header status");
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'h00, st);
      chkByte(st, rxQ.pop_front(), "rx data");
    end
  endtask
  // Radio stores n random bytes back to back
  task automatic rxFill(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      d = 8'($random(seed));
      rxPush <= 1'b1;
      rxPushData <= d;
      if (rxQ.size() < FIFO_DEPTH) rxQ.push_back(d);
    end
    @(posedge clk_sys);
    rxPush <= 1'b0;
    step(2);
  endtask
  // Read the whole table once around plus entry zero again, then every amplifier selection
  task automatic paRead();
    i_host.select();
    i_host.xfer(8'hfe, st);
    for (int i = 0; i < 9; i++) begin
      i_host.xfer(8'h00, st);
      chkByte(st, 8'(pa[i % PA_ENTRIES]), "table read");
    end
    i_host.deselect();
    for (int i = 0; i < PA_ENTRIES; i++) begin
      @(posedge clk_sys);
      paSel <= 3'(i);
      step(3);
      chkByte(paCtrl, 8'(pa[i]), "amplifier control");
    end
  endtask
  // Pins set while deselected, then one select pulse; exp is the strobe index or -1
  task automatic pinCmd(input logic en, input logic sc, input logic dd, input logic [2:0] s,
      input int exp);
    snap = cnt;
    @(posedge clk_sys);
    pinCtrlEn <= en;
    mainState <= s;
    i_host.pins(sc, dd);
    i_host.select();
    chkByte(8'(cnt[0] - snap[0]), 8'h00, "early power down");
    i_host.deselect();
    i_host.pins(1'b0, 1'b0);
    for (int k = 0; k < 5; k++)
      chkByte(8'(cnt[k] - snap[k]), (k == exp) ? 8'h01 : 8'h00, "strobe");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 67770;
    {rst, radioAsleep, sleepEntry, pinCtrlEn, serialMode, gdo1Generic, gdo1Level} = 7'h40;
    {gdo0Level, gdo0In, flushTx, flushRx, txPop, rxPush, mainState, paSel} = 12'h000;
    rxPushData = 8'h00;
    step(8);
    rst <= 1'b0;
    step(4);
    counts();
    chkByte(paCtrl, PA_RESET, "table reset");
    @(posedge clk_sys);
    {gdo1Generic, gdo1Level, mainState} <= {2'b11, ST_RX};
    step(3);
    chkBit(soOe, 1'b1, "generic drive");
    chkBit(soPin, 1'b1, "generic level");
    @(posedge clk_sys);
    gdo1Generic <= 1'b0;
    step(3);
    chkBit(soOe, 1'b0, "tristate default");
    i_host.select();
    chkBit(soOe, 1'b1, "serial out drive");
    txWrite(8'h7f, FIFO_DEPTH + 1);
    i_host.deselect();
    counts();
    for (int i = 0; i < 3; i++) begin
      chkByte(txData, txQ.pop_front(), "tx head");
      @(posedge clk_sys);
      txPop <= 1'b1;
      @(posedge clk_sys);
      txPop <= 1'b0;
      step(1);
    end
    i_host.select();
    txWrite(8'h3f, 1);
    txWrite(8'h3f, 1);
    i_host.deselect();
    counts();
    rxFill(FIFO_DEPTH + 1);
    counts();
    i_host.select();
    rxRead(8'hff, 5);
    i_host.deselect();
    i_host.select();
    rxRead(8'hbf, 1);
    rxRead(8'hbf, 1);
    i_host.deselect();
    counts();
    foreach (flSt[k]) begin
      i_host.select();
      txWrite(8'h7f, 2);
      i_host.deselect();
      rxFill(2);
      @(posedge clk_sys);
      {mainState, flushTx, flushRx} <= {flSt[k], 2'b11};
      @(posedge clk_sys);
      {flushTx, flushRx} <= 2'b00;
      step(2);
      if (flSt[k] inside {ST_IDLE, ST_RXOVF, ST_TXUNF}) begin
        txQ.delete();
        rxQ.delete();
      end
      counts();
    end
    i_host.select();
    txWrite(8'h3f, 1);
    i_host.deselect();
    @(posedge clk_sys);
    mainState <= ST_IDLE;
    i_host.select();
    for (int i = 0; i < 2; i++) begin
      pa[i] = $random(seed) & 255;
      i_host.xfer(8'h3e, st);
      i_host.xfer(8'(pa[i]), st);
    end
    i_host.deselect();
    i_host.select();
    i_host.xfer(8'hbe, st);
    i_host.xfer(8'h00, st);
    chkByte(st, 8'(pa[0]), "single table read");
    i_host.deselect();
    i_host.select();
    i_host.xfer(8'h7e, st);
    for (int i = 0; i < PA_ENTRIES; i++) begin
      pa[i] = $random(seed) & 255;
      i_host.xfer(8'(pa[i]), st);
    end
    i_host.deselect();
    paRead();
    @(posedge clk_sys);
    sleepEntry <= 1'b1;
    @(posedge clk_sys);
    sleepEntry <= 1'b0;
    step(2);
    txQ.delete();
    rxQ.delete();
    for (int i = 1; i < PA_ENTRIES; i++) pa[i] = 0;
    counts();
    paRead();
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      {serialMode, mainState, gdo0In, gdo0Level} <= {1'b1, ST_TX, b[0], ~b[0]};
      step(5);
      chkBit(gdo0Oe, 1'b0, "pin zero released");
      chkBit(serialTxData, b[0], "serial tx data");
      chkBit(gdo0Out, ~b[0], "pin zero level");
    end
    @(posedge clk_sys);
    serialMode <= 1'b0;
    step(5);
    chkBit(gdo0Oe, 1'b1, "pin zero driven");
    pinCmd(1'b1, 1'b0, 1'b1, ST_IDLE, 1);
    pinCmd(1'b1, 1'b1, 1'b0, ST_RX, 2);
    pinCmd(1'b1, 1'b1, 1'b1, ST_IDLE, 3);
    pinCmd(1'b1, 1'b0, 1'b0, ST_IDLE, 0);
    pinCmd(1'b1, 1'b1, 1'b1, ST_RX, -1);
    pinCmd(1'b1, 1'b0, 1'b1, ST_TX, -1);
    pinCmd(1'b0, 1'b0, 1'b1, ST_IDLE, -1);
    @(posedge clk_sys);
    radioAsleep <= 1'b1;
    pinCmd(1'b0, 1'b0, 1'b0, ST_IDLE, 4);
    test_done();
  end
  // Hang guard
  initial begin
    step(100000);
    failures++;
    $display("MISMATCH t=%0t run limit reached", $time);
    test_done();
  end
endmodule
`default_nettype wire

// ===== verilog/rfpc_pkg.sv
// Shared constants for the radio FIFO / power table / pin control block.
// Assumes one system clock; all link pins are sampled, never used as clocks.
package rfpc_pkg;
  // ------------------------------------------------------------
  // Addresses and header layout
  // ------------------------------------------------------------
  localparam logic [5:0] FIFO_ADDR = 6'h3f; // Shared FIFO port
  localparam logic [5:0] PA_ADDR = 6'h3e; // Power ramp table
  localparam int HDR_RW_BIT = 7; // Read when set
  localparam int HDR_BURST_BIT = 6; // Burst when set
  localparam int FIFO_DEPTH = 64; // Bytes per FIFO
  localparam int PA_ENTRIES = 8; // Table entries
  localparam logic [6:0] FIFO_DEPTH_C = 7'h40; // Depth at count width
  localparam logic [2:0] PA_LAST = 3'h7; // Index wraps after this
  // ------------------------------------------------------------
  // Main state codes as shown in the status byte
  // ------------------------------------------------------------
  localparam logic [2:0] ST_IDLE = 3'h0;
  localparam logic [2:0] ST_RX = 3'h1;
  localparam logic [2:0] ST_TX = 3'h2;
  localparam logic [2:0] ST_RXOVF = 3'h6; // Receive FIFO overflow
  localparam logic [2:0] ST_TXUNF = 3'h7; // Transmit FIFO underflow
  localparam int STAT_STATE_LSB = 4; // State field bits 6:4
  localparam logic [3:0] STAT_CNT_MAX = 4'hf; // Count field saturates
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] PA_RESET = 8'h00;
  localparam logic [2:0] BITCNT_RESET = 3'h0;
  // Serial engine phase, one-hot
  typedef enum logic [2:0] {
    PH_HDR = 3'b001, // Waiting for a header byte
    PH_DATA = 3'b010, // Data bytes for FIFO or table
    PH_SKIP = 3'b100 // Burst to a register not handled here
  } rfpc_phase_e;
endpackage

// ===== verilog/rfpc_spi_fifo.sv
// Serial slave for the FIFO port, the power ramp table and three-pin control.
// Assumes the host clocks the link in mode 0, MSB first, far slower than clk_sys.
`timescale 1ns/1ps
`default_nettype none
module rfpc_spi_fifo (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset, high
  input wire logic chip_select_low, // Link select pin, low active
  input wire logic sclkPin, // Link clock pin
  input wire logic siPin, // Link data in pin
  output logic shared_status_pin, // Serial out or generic level
  output logic sharedStatusOe, // High while driving the status pin
  input wire logic general_output_zero, // Pin zero sensed level
  output logic gdo0Out, // Pin zero driven level
  output logic gdo0Oe, // High while driving pin zero
  input wire logic [2:0] mainState, // Radio state code
  input wire logic radioAsleep, // Radio in sleep or oscillator off
  input wire logic sleepEntry, // Pulse as radio enters sleep
  input wire logic pinCtrlEn, // Three-pin control enable
  input wire logic serialMode, // Synchronous or asynchronous serial
  input wire logic gdo1Generic, // Status pin set to a generic signal
  input wire logic gdo1Level, // Generic status level
  input wire logic gdo0Level, // Generic pin zero level
  input wire logic flush_tx_strobe, // Flush request for TX FIFO
  input wire logic flush_rx_strobe, // Flush request for RX FIFO
  input wire logic [2:0] power_level_select, // Table entry select
  output logic [7:0] paCtrl, // Amplifier control byte
  input wire logic txPop, // Radio takes a TX byte
  output logic [7:0] txData, // TX FIFO head
  output logic [6:0] txCount, // TX FIFO fill
  input wire logic rxPush, // Radio stores an RX byte
  input wire logic [7:0] rxPushData, // RX byte from radio
  output logic [6:0] rxCount, // RX FIFO fill
  output logic serialTxData, // Serial transmit data to modem
  output logic power_down_strobe, // Pulse: power down
  output logic transmit_strobe, // Pulse: enter transmit
  output logic idle_strobe, // Pulse: enter idle
  output logic receive_strobe, // Pulse: enter receive
  output logic wakeStrobe // Pulse: wake into idle
);
  import rfpc_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Saturate a FIFO fill or free figure to the 4-bit status field
  function automatic logic [3:0] satNib(input logic [6:0] v);
    satNib = (v > 7'(STAT_CNT_MAX)) ? STAT_CNT_MAX : v[3:0];
  endfunction
  // Build a status byte; top bit is chip ready, always low here
  function automatic logic [7:0] statByte(input logic [2:0] s, input logic [6:0] v);
    statByte = {1'b0, s, satNib(v)};
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] csSync_r, ckSync_r, siSync_r, g0Sync_r; // Two-stage chains
  logic csPrev_r, ckPrev_r; // Edge history, read from stage two only
  // Every pin passes two flops before any logic looks at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      csSync_r <= 2'h3;
      ckSync_r <= 2'h0;
      siSync_r <= 2'h0;
      g0Sync_r <= 2'h0;
      csPrev_r <= 1'b1;
      ckPrev_r <= 1'b0;
    end else begin
      csSync_r <= {csSync_r[0], chip_select_low};
      ckSync_r <= {ckSync_r[0], sclkPin};
      siSync_r <= {siSync_r[0], siPin};
      g0Sync_r <= {g0Sync_r[0], general_output_zero};
      csPrev_r <= csSync_r[1];
      ckPrev_r <= ckSync_r[1];
    end
  end
  logic csLow, csFall, csRise, ckRise, ckFall;
  assign csLow = ~csSync_r[1];
  assign csFall = csPrev_r & ~csSync_r[1];
  assign csRise = ~csPrev_r & csSync_r[1];
  assign ckRise = csLow & ~ckPrev_r & ckSync_r[1];
  assign ckFall = csLow & ckPrev_r & ~ckSync_r[1];

  // ------------------------------------------------------------
  // Serial engine state
  // ------------------------------------------------------------
  rfpc_phase_e phase_r; // Header, data or skip phase
  logic [2:0] bitCnt_r; // Bits taken in this byte
  logic [7:0] shIn_r; // Incoming shift register
  logic [7:0] shOut_r; // Outgoing shift register
  logic skipShift_r; // Next falling edge keeps the fresh load
  logic hdrRw_r, hdrBurst_r; // Latched header fields
  logic [5:0] addr_r; // Burst address counter
  logic [2:0] paIdx_r; // Table index counter
  logic [7:0] paTab_r [PA_ENTRIES]; // Power ramp table
  logic [7:0] txMem_r [FIFO_DEPTH]; // TX storage
  logic [7:0] rxMem_r [FIFO_DEPTH]; // RX storage
  logic [5:0] txWr_r, txRd_r, rxWr_r, rxRd_r; // FIFO pointers
  logic [7:0] byteIn; // Byte completed this cycle
  logic byteDone; // Eighth bit taken
  logic hdrDone, dataDone; // Byte kind at completion
  logic txPush, rxPop; // FIFO moves from the link
  logic flushTx, flushRx; // Effective flushes
  logic flushOk; // State allows a flush

  assign byteIn = {shIn_r[6:0], siSync_r[1]};
  assign byteDone = ckRise & (bitCnt_r == 3'h7);
  assign hdrDone = byteDone & (phase_r == PH_HDR);
  assign dataDone = byteDone & (phase_r == PH_DATA);
  // Writes into a full FIFO are dropped, reads from empty leave it empty
  assign txPush = dataDone & ~hdrRw_r & (addr_r == FIFO_ADDR) & (txCount != FIFO_DEPTH_C);
  assign rxPop = dataDone & hdrRw_r & (addr_r == FIFO_ADDR) & (rxCount != 7'h00);
  assign flushOk = (mainState == ST_IDLE) | (mainState == ST_TXUNF) | (mainState == ST_RXOVF);
  assign flushTx = (flush_tx_strobe & flushOk) | sleepEntry;
  assign flushRx = (flush_rx_strobe & flushOk) | sleepEntry;

  // Bit counter and input shifter; deselect restarts at a header
  always_ff @(posedge clk_sys) begin
    if (rst || !csLow) begin
      bitCnt_r <= BITCNT_RESET;
      shIn_r <= 8'h00;
    end else if (ckRise) begin
      bitCnt_r <= bitCnt_r + 3'h1;
      shIn_r <= byteIn;
    end
  end

  // Phase and header capture
  always_ff @(posedge clk_sys) begin
    if (rst || !csLow) begin
      phase_r <= PH_HDR;
      hdrRw_r <= 1'b0;
      hdrBurst_r <= 1'b0;
      addr_r <= 6'h00;
    end else if (hdrDone) begin
      hdrRw_r <= byteIn[HDR_RW_BIT];
      hdrBurst_r <= byteIn[HDR_BURST_BIT];
      addr_r <= byteIn[5:0];
      // Only the FIFO port and the table take data bytes here
      if (byteIn[5:0] == FIFO_ADDR || byteIn[5:0] == PA_ADDR)
        phase_r <= PH_DATA;
      else if (byteIn[HDR_BURST_BIT])
        phase_r <= PH_SKIP; // Burst to foreign registers ends at deselect
    end else if (dataDone) begin
      if (!hdrBurst_r)
        phase_r <= PH_HDR;
      else if (addr_r != FIFO_ADDR && addr_r != PA_ADDR)
        addr_r <= addr_r + 6'h01;
    end
  end

  // Output shifter: status on headers and TX writes, data on reads and table writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shOut_r <= 8'h00;
      skipShift_r <= 1'b0;
    end else if (csFall) begin
      shOut_r <= statByte(mainState, FIFO_DEPTH_C - txCount);
      skipShift_r <= 1'b0;
    end else if (hdrDone) begin
      skipShift_r <= 1'b1;
      if (byteIn[5:0] == PA_ADDR)
        shOut_r <= paTab_r[paIdx_r];
      else if (byteIn[5:0] == FIFO_ADDR && byteIn[HDR_RW_BIT])
        shOut_r <= rxMem_r[rxRd_r];
      else
        shOut_r <= statByte(mainState, FIFO_DEPTH_C - txCount);
    end else if (dataDone) begin
      skipShift_r <= 1'b1;
      // Next header already counts the byte written in this cycle
      if (!hdrBurst_r)
        shOut_r <= statByte(mainState, FIFO_DEPTH_C - txCount - 7'(txPush));
      else if (addr_r == PA_ADDR)
        shOut_r <= paTab_r[paIdx_r + 3'h1];
      else if (addr_r == FIFO_ADDR && hdrRw_r)
        shOut_r <= rxMem_r[rxRd_r + 6'(rxPop)];
      else
        shOut_r <= statByte(mainState, FIFO_DEPTH_C - txCount - 7'(txPush));
    end else if (ckFall) begin
      skipShift_r <= 1'b0;
      if (!skipShift_r)
        shOut_r <= {shOut_r[6:0], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // Power ramp table
  // ------------------------------------------------------------
  // Index follows every table data byte and clears while deselected
  always_ff @(posedge clk_sys) begin
    if (rst || !csLow)
      paIdx_r <= 3'h0;
    else if (dataDone && addr_r == PA_ADDR)
      paIdx_r <= (paIdx_r == PA_LAST) ? 3'h0 : paIdx_r + 3'h1;
  end
  // Entry zero survives sleep, the rest are lost
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < PA_ENTRIES; i++)
        paTab_r[i] <= PA_RESET;
    end else begin
      if (sleepEntry)
        for (int i = 1; i < PA_ENTRIES; i++)
          paTab_r[i] <= PA_RESET;
      if (dataDone && addr_r == PA_ADDR && !hdrRw_r)
        paTab_r[paIdx_r] <= byteIn;
    end
  end
  // Registered amplifier drive from the selected entry
  always_ff @(posedge clk_sys) begin
    if (rst)
      paCtrl <= PA_RESET;
    else
      paCtrl <= paTab_r[power_level_select];
  end

  // ------------------------------------------------------------
  // FIFOs
  // ------------------------------------------------------------
  // TX: filled by the link, drained by the radio
  always_ff @(posedge clk_sys) begin
    if (rst || flushTx) begin
      txWr_r <= 6'h00;
      txRd_r <= 6'h00;
      txCount <= 7'h00;
    end else begin
      if (txPush) begin
        txMem_r[txWr_r] <= byteIn;
        txWr_r <= txWr_r + 6'h01;
      end
      if (txPop && txCount != 7'h00)
        txRd_r <= txRd_r + 6'h01;
      txCount <= txCount + 7'(txPush) - 7'(txPop && txCount != 7'h00);
    end
  end
  assign txData = txMem_r[txRd_r];
  // RX: filled by the radio, drained by the link
  always_ff @(posedge clk_sys) begin
    if (rst || flushRx) begin
      rxWr_r <= 6'h00;
      rxRd_r <= 6'h00;
      rxCount <= 7'h00;
    end else begin
      if (rxPush && rxCount != FIFO_DEPTH_C) begin
        rxMem_r[rxWr_r] <= rxPushData;
        rxWr_r <= rxWr_r + 6'h01;
      end
      if (rxPop)
        rxRd_r <= rxRd_r + 6'h01;
      rxCount <= rxCount + 7'(rxPush && rxCount != FIFO_DEPTH_C) - 7'(rxPop);
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  logic serialTxUse; // Pin zero serves as serial data input
  assign serialTxUse = serialMode & (mainState == ST_TX);
  // Status pin: serial out while selected, else generic or released
  always_comb begin
    shared_status_pin = 1'b0;
    sharedStatusOe = 1'b0;
    if (csLow) begin
      shared_status_pin = shOut_r[7];
      sharedStatusOe = 1'b1;
    end else if (gdo1Generic) begin
      shared_status_pin = gdo1Level;
      sharedStatusOe = 1'b1;
    end
  end
  // Pin zero is released when it carries transmit data in
  assign gdo0Out = gdo0Level;
  assign gdo0Oe = ~serialTxUse;
  always_ff @(posedge clk_sys) begin
    if (rst)
      serialTxData <= 1'b0;
    else
      serialTxData <= serialTxUse & g0Sync_r[1];
  end

  // ------------------------------------------------------------
  // Three-pin radio control
  // ------------------------------------------------------------
  logic pwdPend_r; // Power-down waits for deselect
  // Latch clock and data at select fall; only real changes strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      transmit_strobe <= 1'b0;
      idle_strobe <= 1'b0;
      receive_strobe <= 1'b0;
      power_down_strobe <= 1'b0;
      wakeStrobe <= 1'b0;
      pwdPend_r <= 1'b0;
    end else begin
      transmit_strobe <= csFall & pinCtrlEn & ~ckSync_r[1] & siSync_r[1]
                         & (mainState != ST_TX);
      idle_strobe <= csFall & pinCtrlEn & ckSync_r[1] & ~siSync_r[1]
                     & (mainState != ST_IDLE) & ~radioAsleep;
      receive_strobe <= csFall & pinCtrlEn & ckSync_r[1] & siSync_r[1]
                        & (mainState != ST_RX);
      wakeStrobe <= csFall & radioAsleep;
      power_down_strobe <= csRise & pwdPend_r;
      if (csFall)
        pwdPend_r <= pinCtrlEn & ~ckSync_r[1] & ~siSync_r[1] & ~radioAsleep;
      else if (csRise)
        pwdPend_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_selFallRx;
    csFall && pinCtrlEn && ckSync_r[1] && siSync_r[1] && mainState != ST_RX;
  endsequence
  property p_rxStrobe;
    @(posedge clk_sys) disable iff (rst) s_selFallRx |=> receive_strobe;
  endproperty
  a_rxStrobe: assert property (p_rxStrobe) else $error("receive strobe missing");
  property p_noRestart;
    @(posedge clk_sys) disable iff (rst)
      (csFall && mainState == ST_RX) |=> !receive_strobe;
  endproperty
  a_noRestart: assert property (p_noRestart) else $error("present state restarted");
  property p_pinDisabled;
    @(posedge clk_sys) disable iff (rst)
      !$past(pinCtrlEn) |-> !(transmit_strobe || idle_strobe || receive_strobe);
  endproperty
  a_pinDisabled: assert property (p_pinDisabled) else $error("strobe while disabled");
  property p_pwdDeferred;
    @(posedge clk_sys) disable iff (rst) power_down_strobe |-> $past(csRise);
  endproperty
  a_pwdDeferred: assert property (p_pwdDeferred) else $error("power down not deferred");
  property p_idxClear;
    @(posedge clk_sys) disable iff (rst) $rose(csSync_r[1]) |=> paIdx_r == 3'h0;
  endproperty
  a_idxClear: assert property (p_idxClear) else $error("table index not cleared");
  property p_idxWrap;
    @(posedge clk_sys) disable iff (rst)
      (dataDone && addr_r == PA_ADDR && paIdx_r == PA_LAST && csLow) |=> paIdx_r == 3'h0;
  endproperty
  a_idxWrap: assert property (p_idxWrap) else $error("table index did not wrap");
  property p_sleepFlush;
    @(posedge clk_sys) disable iff (rst) sleepEntry |=> txCount == 7'h00 && rxCount == 7'h00;
  endproperty
  a_sleepFlush: assert property (p_sleepFlush) else $error("FIFOs kept over sleep");
  property p_flushGuard;
    @(posedge clk_sys) disable iff (rst)
      (flush_tx_strobe && mainState == ST_RX && !sleepEntry && !txPop && txCount != 7'h00)
        |=> txCount != 7'h00;
  endproperty
  a_flushGuard: assert property (p_flushGuard) else $error("flush honoured in RX");
  property p_soDrive;
    @(posedge clk_sys) disable iff (rst) csLow |-> sharedStatusOe && shared_status_pin == shOut_r[7];
  endproperty
  a_soDrive: assert property (p_soDrive) else $error("status pin not serial out");
  property p_txPush;
    @(posedge clk_sys) disable iff (rst)
      (txPush && !txPop && !flushTx) |=> txCount == $past(txCount) + 7'h01;
  endproperty
  a_txPush: assert property (p_txPush) else $error("TX write lost");
endmodule
`default_nettype wire
